// file: include/spi_port_params.svh
// Constants of the serial register access port: control byte layout,
// reset values, register set spans and word widths.
// Assumes inclusion by bare name from the core files.
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// Control byte layout
`define CTRL_BITS 6'h07
`define CTRL_DEV_MSB 7
`define CTRL_DEV_LSB 6
`define CTRL_REG_MSB 5
`define CTRL_REG_LSB 1
`define CTRL_RW_BIT 0

// Device address reset value
`define DEV_ADDR_DEFAULT 2'h1

// Comm config reset values
`define READ_LOOP_DEFAULT 2'h2
`define WRITE_LOOP_DEFAULT 1'h1
`define WIDTH_DEFAULT 2'h1
`define LATCH_DEFAULT 1'h1

// Comm config register address and field positions in a written word
`define COMM_ADDR 5'h0C
`define COMM_LATCH_BIT 0
`define COMM_WIDTH_LSB 1
`define COMM_WRITE_BIT 3
`define COMM_READ_LSB 4

// Write protection
`define LOCK_KEY 8'hA5
`define LOCK_ADDR 5'h1F
`define FIRST_WRITABLE 5'h08

// Register set spans as log2 of the set size
`define GROUP_LOG2 3'h1
`define TYPE_LOG2 3'h3
`define FULL_LOG2 3'h5

// Loop field encodings
`define LOOP_STATIC 2'h0
`define LOOP_GROUP 2'h1
`define LOOP_TYPE 2'h2
`define LOOP_FULL 2'h3

// Word widths in bits
`define WIDTH_16 2'h0
`define WIDTH_24 2'h1
`define BITS_16 6'h10
`define BITS_24 6'h18
`define BITS_32 6'h20

`define WORD_ZERO 32'h0000_0000

`endif

// file: include/spi_port_pkg.sv
// Types of the serial register access port: transfer states and the
// packed state records of the core and of the pin synchroniser.
// Assumes the constants header is on the include path.
package spi_port_pkg;

    typedef enum logic [1:0] {
        ST_CTRL = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h3,
        ST_IGNORE = 2'h2
    } mode_type;

    typedef struct packed {
        mode_type state;
        logic sck_prev;
        logic csn_prev;
        logic [31:0] shift_in;
        logic [31:0] shift_out;
        logic [5:0] bit_cnt;
        logic [4:0] ptr;
        logic load_pending;
        logic word_fresh;
        logic sdo;
        logic sdo_oe;
        logic [4:0] rd_addr;
        logic rd_start;
        logic [4:0] wr_addr;
        logic [31:0] wr_data;
        logic wr_stb;
        logic [1:0] read_loop;
        logic write_loop;
        logic [1:0] data_width;
        logic latch_all;
    } state_type;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } sync_type;

endpackage : spi_port_pkg

// file: core/pin_sync.sv
// Two-stage synchroniser for the three serial input pins.
// Assumes pins are asynchronous to clock; outputs are on clock.
`timescale 1ns/100ps
`include "spi_port_params.svh"

module pin_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [2:0] pins,
    output logic [2:0] pins_sync
);

    spi_port_pkg::sync_type s_reg;
    spi_port_pkg::sync_type s_next;

    // First stage feeds only the second stage
    always_comb begin
        s_next = s_reg;
        if (clk_en) begin
            s_next.meta = pins;
            s_next.stable = s_reg.meta;
        end
    end

    // Chip select idles high so it resets high
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '{meta: 3'h4, stable: 3'h4};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins_sync = s_reg.stable;

endmodule : pin_sync

// file: core/spi_register_access_port.sv
// Serial slave front end: control byte decode, register read and write
// sequencing with a looping address pointer and write lock.
// Assumes the register map sits outside: it answers rd_addr on rd_data
// combinationally and takes wr_addr/wr_data on wr_stb.
`timescale 1ns/100ps
`include "spi_port_params.svh"

// Notes on behaviour
// - Control byte: two device address bits, five register bits, then read/write bit.
// - Data output stays high impedance while the control byte arrives.
// - Transaction acted on only when device address matches own address, default 01.
// - First register read out is the control byte's register address.
// - With chip select low, further registers follow; read loop steers address.
// - Data output changes on serial clock falling edge.
// - Write loads control byte address first, then more per write loop bit.
// - Serial input sampled on serial clock rising edge.
// - Data output high impedance throughout every write.
// - Writes to non-writable addresses change nothing, pointer stays.
// - Continuous mode keeps serving registers until chip select rises.
// - Pointer steps through the set and wraps to the set's first address.
// - Read loop: 00 static, 01 groups, 10 types (default), 11 full map.
// - Write loop: 0 static, 1 types (default).
// - Serial input after the control byte is ignored in reads.
// - Reset: channels latched together, read loop types, width 24 bits.
// - Mode 0,0: next register's MSB after read, new MSB on sample ready.
// - Mode 1,1: output holds last driven level after a read.
// - Lock key not A5 makes every address except 1F non-writable.
// - Chip select rising edge aborts and returns to idle.
// - Register words are 16, 24 or 32 bits per width field.
module spi_register_access_port #(
    parameter logic [1:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic sample_ready_pulse,
    input wire logic [7:0] lock_key,
    output logic [4:0] rd_addr,
    input wire logic [31:0] rd_data,
    output logic rd_start,
    output logic [4:0] wr_addr,
    output logic [31:0] wr_data,
    output logic wr_stb,
    output logic [1:0] read_loop,
    output logic write_loop,
    output logic [1:0] data_width,
    output logic latch_all_channels
);

    spi_port_pkg::state_type st_reg;
    spi_port_pkg::state_type st_next;
    logic [2:0] pins_s;
    logic csn_s;
    logic sck_s;
    logic sdi_s;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] ctrl_byte;
    logic ctrl_last;
    logic [5:0] bits_now;
    logic [31:0] word_in;

    pin_sync u_pin_sync (
        .clock(clock),
        .rstn(rstn),
        .clk_en(clk_en),
        .pins({cs_n, sck, sdi}),
        .pins_sync(pins_s)
    );

    assign csn_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign sdi_s = pins_s[0];
    assign sck_rise = sck_s & ~st_reg.sck_prev;
    assign sck_fall = ~sck_s & st_reg.sck_prev;

    // Word length from the width field
    function automatic logic [5:0] word_bits(input logic [1:0] sel);
        case (sel)
            `WIDTH_16: word_bits = `BITS_16;
            `WIDTH_24: word_bits = `BITS_24;
            default: word_bits = `BITS_32;
        endcase
    endfunction : word_bits

    // Next pointer inside an aligned set of 2**lg registers
    function automatic logic [4:0] step_in_set(input logic [4:0] p, input logic [2:0] lg);
        logic [4:0] mask;
        mask = 5'((6'h01 << lg) - 6'h01);
        step_in_set = (p & ~mask) | (5'(p + 5'h01) & mask);
    endfunction : step_in_set

    function automatic logic [4:0] read_step(input logic [4:0] p, input logic [1:0] loop);
        case (loop)
            `LOOP_GROUP: read_step = step_in_set(p, `GROUP_LOG2);
            `LOOP_TYPE: read_step = step_in_set(p, `TYPE_LOG2);
            `LOOP_FULL: read_step = step_in_set(p, `FULL_LOG2);
            default: read_step = p;
        endcase
    endfunction : read_step

    function automatic logic writable(input logic [4:0] a, input logic [7:0] key);
        if (key != `LOCK_KEY) begin
            writable = (a == `LOCK_ADDR);
        end else begin
            writable = (a >= `FIRST_WRITABLE);
        end
    endfunction : writable

    assign ctrl_byte = {st_reg.shift_in[6:0], sdi_s};
    assign ctrl_last = ~csn_s && st_reg.state == spi_port_pkg::ST_CTRL && sck_rise
        && st_reg.bit_cnt == `CTRL_BITS;
    assign bits_now = word_bits(st_reg.data_width);
    assign word_in = {st_reg.shift_in[30:0], sdi_s};

    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            st_next.rd_start = 1'b0;
            st_next.wr_stb = 1'b0;
            st_next.sck_prev = sck_s;
            st_next.csn_prev = csn_s;
            if (csn_s) begin
                st_next.state = spi_port_pkg::ST_CTRL;
                st_next.bit_cnt = 6'h00;
                st_next.shift_in = `WORD_ZERO;
                st_next.sdo_oe = 1'b0;
                st_next.load_pending = 1'b0;
                st_next.word_fresh = 1'b0;
            end else begin
                case (st_reg.state)
                    spi_port_pkg::ST_CTRL: begin
                        if (sck_rise) begin
                            st_next.shift_in = word_in;
                            st_next.bit_cnt = 6'(st_reg.bit_cnt + 6'h01);
                        end
                        if (ctrl_last) begin
                            st_next.bit_cnt = 6'h00;
                            st_next.shift_in = `WORD_ZERO;
                            if (ctrl_byte[`CTRL_DEV_MSB:`CTRL_DEV_LSB] != DEV_ADDR) begin
                                st_next.state = spi_port_pkg::ST_IGNORE;
                            end else if (ctrl_byte[`CTRL_RW_BIT]) begin
                                st_next.state = spi_port_pkg::ST_READ;
                                st_next.ptr = ctrl_byte[`CTRL_REG_MSB:`CTRL_REG_LSB];
                                st_next.rd_addr = ctrl_byte[`CTRL_REG_MSB:`CTRL_REG_LSB];
                                st_next.load_pending = 1'b1;
                            end else begin
                                st_next.state = spi_port_pkg::ST_WRITE;
                                st_next.ptr = ctrl_byte[`CTRL_REG_MSB:`CTRL_REG_LSB];
                            end
                        end
                    end
                    spi_port_pkg::ST_READ: begin
                        if (sck_fall && st_reg.load_pending) begin
                            st_next.shift_out = rd_data << (6'h20 - bits_now);
                            st_next.sdo = rd_data[5'(bits_now - 6'h01)];
                            st_next.sdo_oe = 1'b1;
                            st_next.rd_start = 1'b1;
                            st_next.load_pending = 1'b0;
                            st_next.word_fresh = 1'b1;
                        end else if (sck_fall && st_reg.bit_cnt != 6'h00) begin
                            st_next.shift_out = {st_reg.shift_out[30:0], 1'b0};
                            st_next.sdo = st_reg.shift_out[30];
                        end else if (sample_ready_pulse && st_reg.word_fresh && !sck_s) begin
                            st_next.shift_out = rd_data << (6'h20 - bits_now);
                            st_next.sdo = rd_data[5'(bits_now - 6'h01)];
                            st_next.rd_start = 1'b1;
                        end
                        if (sck_rise && !st_reg.load_pending) begin
                            st_next.word_fresh = 1'b0;
                            st_next.bit_cnt = 6'(st_reg.bit_cnt + 6'h01);
                            if (6'(st_reg.bit_cnt + 6'h01) == bits_now) begin
                                st_next.bit_cnt = 6'h00;
                                st_next.ptr = read_step(st_reg.ptr, st_reg.read_loop);
                                st_next.rd_addr = read_step(st_reg.ptr, st_reg.read_loop);
                                st_next.load_pending = 1'b1;
                            end
                        end
                    end
                    spi_port_pkg::ST_WRITE: begin
                        st_next.sdo_oe = 1'b0;
                        if (sck_rise) begin
                            st_next.shift_in = word_in;
                            st_next.bit_cnt = 6'(st_reg.bit_cnt + 6'h01);
                            if (6'(st_reg.bit_cnt + 6'h01) == bits_now) begin
                                st_next.bit_cnt = 6'h00;
                                st_next.shift_in = `WORD_ZERO;
                                if (writable(st_reg.ptr, lock_key)) begin
                                    st_next.wr_stb = 1'b1;
                                    st_next.wr_addr = st_reg.ptr;
                                    st_next.wr_data = word_in;
                                    if (st_reg.write_loop) begin
                                        st_next.ptr = step_in_set(st_reg.ptr, `TYPE_LOG2);
                                    end
                                    if (st_reg.ptr == `COMM_ADDR) begin
                                        st_next.latch_all = word_in[`COMM_LATCH_BIT];
                                        st_next.data_width =
                                            word_in[`COMM_WIDTH_LSB +: 2];
                                        st_next.write_loop = word_in[`COMM_WRITE_BIT];
                                        st_next.read_loop = word_in[`COMM_READ_LSB +: 2];
                                    end
                                end
                            end
                        end
                    end
                    spi_port_pkg::ST_IGNORE: begin
                        st_next.sdo_oe = 1'b0;
                    end
                    default: begin
                        st_next.state = spi_port_pkg::ST_CTRL;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.state <= spi_port_pkg::ST_CTRL;
            st_reg.csn_prev <= 1'b1;
            st_reg.read_loop <= `READ_LOOP_DEFAULT;
            st_reg.write_loop <= `WRITE_LOOP_DEFAULT;
            st_reg.data_width <= `WIDTH_DEFAULT;
            st_reg.latch_all <= `LATCH_DEFAULT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sdo = st_reg.sdo;
    assign sdo_oe = st_reg.sdo_oe;
    assign rd_addr = st_reg.rd_addr;
    assign rd_start = st_reg.rd_start;
    assign wr_addr = st_reg.wr_addr;
    assign wr_data = st_reg.wr_data;
    assign wr_stb = st_reg.wr_stb;
    assign read_loop = st_reg.read_loop;
    assign write_loop = st_reg.write_loop;
    assign data_width = st_reg.data_width;
    assign latch_all_channels = st_reg.latch_all;

    // Checks

    property p_ctrl_hiz;
        @(posedge clock) disable iff (!rstn)
        st_reg.state == spi_port_pkg::ST_CTRL |-> !sdo_oe;
    endproperty
    a_ctrl_hiz: assert property (p_ctrl_hiz) else $error("output driven in control byte");

    property p_write_hiz;
        @(posedge clock) disable iff (!rstn)
        st_reg.state == spi_port_pkg::ST_WRITE |=> !sdo_oe;
    endproperty
    a_write_hiz: assert property (p_write_hiz) else $error("output driven in write");

    property p_ignore_hiz;
        @(posedge clock) disable iff (!rstn)
        st_reg.state == spi_port_pkg::ST_IGNORE |=> !sdo_oe;
    endproperty
    a_ignore_hiz: assert property (p_ignore_hiz) else $error("output driven when ignored");

    sequence s_cs_release;
        clk_en && csn_s && !st_reg.csn_prev;
    endsequence
    sequence s_idle_after;
        st_reg.state == spi_port_pkg::ST_CTRL && !sdo_oe && st_reg.bit_cnt == 6'h00;
    endsequence
    property p_abort;
        @(posedge clock) disable iff (!rstn)
        s_cs_release |=> s_idle_after;
    endproperty
    a_abort: assert property (p_abort) else $error("chip select rise did not abort");

    property p_addr_match;
        @(posedge clock) disable iff (!rstn)
        (clk_en && ctrl_last && ctrl_byte[7:6] != DEV_ADDR)
            |=> st_reg.state == spi_port_pkg::ST_IGNORE;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("mismatch not ignored");

    property p_first_read;
        @(posedge clock) disable iff (!rstn)
        (clk_en && ctrl_last && ctrl_byte[7:6] == DEV_ADDR && ctrl_byte[0])
            |=> st_reg.state == spi_port_pkg::ST_READ && rd_addr == $past(ctrl_byte[5:1]);
    endproperty
    a_first_read: assert property (p_first_read) else $error("first read address wrong");

    property p_lock;
        @(posedge clock) disable iff (!rstn)
        (wr_stb && $past(lock_key) != `LOCK_KEY) |-> wr_addr == `LOCK_ADDR;
    endproperty
    a_lock: assert property (p_lock) else $error("write passed lock");

    property p_no_bad_write;
        @(posedge clock) disable iff (!rstn)
        wr_stb |-> wr_addr >= `FIRST_WRITABLE;
    endproperty
    a_no_bad_write: assert property (p_no_bad_write) else $error("read-only address written");

    property p_sample_rise;
        @(posedge clock) disable iff (!rstn)
        wr_stb |-> $past(sck_s) && !$past(st_reg.sck_prev);
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("write not on clock rise");

    property p_sdo_fall;
        @(posedge clock) disable iff (!rstn)
        ($past(sdo_oe) && sdo_oe && $changed(sdo)) |-> !$past(sck_s);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("output changed with clock high");

    property p_load_pulse;
        @(posedge clock) disable iff (!rstn)
        (clk_en && !csn_s && st_reg.state == spi_port_pkg::ST_READ && sck_fall
            && st_reg.load_pending) |=> rd_start && sdo_oe;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("word load missing");

    property p_type_wrap;
        @(posedge clock) disable iff (!rstn)
        (clk_en && !csn_s && st_reg.state == spi_port_pkg::ST_READ && sck_rise
            && !st_reg.load_pending && 6'(st_reg.bit_cnt + 6'h01) == bits_now
            && st_reg.read_loop == `LOOP_TYPE && st_reg.ptr[2:0] == 3'h7)
            |=> (rd_addr ^ $past(st_reg.ptr)) == 5'h07;
    endproperty
    a_type_wrap: assert property (p_type_wrap) else $error("type set did not wrap");

endmodule : spi_register_access_port

// file: tb/host_master.sv
// Host side model: a mode 0,0 or 1,1 serial master that frames transfers and
// shifts words MSB first while capturing the slave's reply bit by bit.
// Assumes the bench resolves the data-out wire and calls these tasks.
`timescale 1ns/100ps

module host_master (
    input wire logic clock,
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo_line,
    input wire logic sdo_oe
);
    logic [31:0] rx_word;
    logic [31:0] rx_last;
    logic oe_seen;
    logic oe_last;
    logic idle_high;
    event word_done;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        rx_word = 32'h0000_0000;
        rx_last = 32'h0000_0000;
        oe_seen = 1'b0;
        oe_last = 1'b0;
        idle_high = 1'b0;
    end

    // Clock polarity only changes while deselected
    task automatic set_mode(input logic hi);
        @(negedge clock);
        idle_high = hi;
        sck = hi;
        repeat (4) @(negedge clock);
    endtask : set_mode

    task automatic take_bit();
        rx_word = {rx_word[30:0], sdo_line};
        oe_seen = oe_seen | sdo_oe;
    endtask : take_bit

    task automatic begin_frame();
        @(negedge clock);
        cs_n = 1'b0;
        repeat (2) @(negedge clock);
    endtask : begin_frame

    // Released data line shows the inverse of its last level
    task automatic end_frame();
        @(negedge clock);
        cs_n = 1'b1;
        sdi = ~sdi;
        repeat (6) @(negedge clock);
    endtask : end_frame

    task automatic xfer(input logic [31:0] w, input int nb);
        int i;
        rx_word = 32'h0000_0000;
        oe_seen = 1'b0;
        for (i = nb - 1; i >= 0; i--) begin
            sdi = w[i];
            // Mode 1,1 starts each bit with a fall
            if (idle_high) sck = 1'b0;
            repeat (3) @(negedge clock);
            if (idle_high) take_bit();
            @(negedge clock);
            sck = 1'b1;
            repeat (3) @(negedge clock);
            // Sample late in the high phase, after the synchronised fall update
            if (!idle_high) take_bit();
            @(negedge clock);
            if (!idle_high) sck = 1'b0;
        end
        // Copies survive the next call clearing the shift register
        rx_last = rx_word;
        oe_last = oe_seen;
        ->word_done;
    endtask : xfer
endmodule : host_master

// file: tb/test_spi_register_access_port.sv
// Self-checking bench for the serial register access port.
// Assumes a 25 MHz clock, a behavioural register map and the host model.
`timescale 1ns/100ps

module test_spi_register_access_port;
    logic clock, rstn, sample_ready_pulse, sdo, sdo_oe, rd_start, wr_stb;
    logic write_loop, latch_all_channels, cs_n, sck, sdi, wl, clk_en, flip;
    logic [7:0] lock_key;
    logic [4:0] rd_addr, wr_addr;
    logic [31:0] rd_data, wr_data, seed, cfg_word;
    logic [1:0] read_loop, data_width, rl, wd, m;
    logic [33:0] note;
    wire sdo_line;
    logic [36:0] wq[$];
    logic [33:0] rq[$];
    int failures, samples_checked;

    function automatic logic [31:0] map(input logic [4:0] a);
        return {4{a[0], 2'h2, a}};
    endfunction : map

    function automatic logic [4:0] nxt(input logic [4:0] a, input logic [1:0] lm);
        logic [4:0] s;
        s = (lm == 2'h0) ? 5'h00 : (lm == 2'h1) ? 5'h01 : (lm == 2'h2) ? 5'h07 : 5'h1F;
        return (a & ~s) | ((a + 5'h01) & s);
    endfunction : nxt

    function automatic int bits(input logic [1:0] w);
        return (w == 2'h0) ? 16 : (w == 2'h1) ? 24 : 32;
    endfunction : bits

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    assign sdo_line = sdo_oe ? sdo : 1'bz;
    assign rd_data = map(rd_addr) ^ {32{flip}};

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    spi_register_access_port i_spi_register_access_port (
        .clock(clock), .rstn(rstn), .clk_en(clk_en), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .sample_ready_pulse(sample_ready_pulse),
        .lock_key(lock_key), .rd_addr(rd_addr), .rd_data(rd_data), .rd_start(rd_start),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_stb(wr_stb), .read_loop(read_loop),
        .write_loop(write_loop), .data_width(data_width),
        .latch_all_channels(latch_all_channels)
    );

    host_master i_host_master (
        .clock(clock), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_line(sdo_line),
        .sdo_oe(sdo_oe)
    );

    task automatic fail(input string msg);
        failures++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) fail(msg);
    endtask : check

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic send(input logic [31:0] w, input int nb, input logic chk, input logic oe,
                        input logic [31:0] exp);
        rq.push_back({chk, oe, exp});
        i_host_master.xfer(w, nb);
    endtask : send

    task automatic seq(input logic [1:0] dev, input logic [4:0] a, input logic rd,
                       input int cnt, input logic ok);
        logic [31:0] d, mk, e;
        logic [4:0] ea;
        logic lb;
        int nb, k;
        ea = a;
        nb = bits(wd);
        mk = (nb == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << nb) - 32'h0000_0001);
        i_host_master.begin_frame();
        send({24'h00_0000, dev, a, rd}, 8, 1'b0, 1'b0, 32'h0000_0000);
        for (k = 0; k < cnt; k++) begin
            d = (!rd && ea == 5'h0C) ? cfg_word : (rnd() & mk);
            if (rd) begin
                e = map(ea) & mk;
                send(d, nb, ok, ok, e);
                lb = e[0];
                ea = nxt(ea, rl);
            end else begin
                if (ok) wq.push_back({ea, d});
                send(d, nb, 1'b0, 1'b0, 32'h0000_0000);
                ea = wl ? nxt(ea, 2'h2) : ea;
            end
        end
        if (rd && ok) begin
            repeat (6) @(negedge clock);
            e = map(ea);
            if (i_host_master.idle_high) begin
                check(sdo_line === lb, "held level");
            end else begin
                check(sdo_line === e[nb - 1], "parked msb");
                flip = 1'b1;
                sample_ready_pulse = 1'b1;
                @(negedge clock);
                check(rd_start === 1'b1 && sdo_line === ~e[nb - 1], "sample refresh");
                sample_ready_pulse = 1'b0;
                flip = 1'b0;
            end
        end
        i_host_master.end_frame();
        for (k = 0; k < 20 && wq.size() != 0; k++) @(negedge clock);
        if (wq.size() != 0) fail("register write missing");
    endtask : seq

    always @(negedge clock) begin
        if (wr_stb === 1'b1) begin
            samples_checked++;
            if (wq.size() == 0) fail("unexpected register write");
            else if ({wr_addr, wr_data} !== wq.pop_front()) fail("register write differs");
        end
    end

    always @(i_host_master.word_done) begin
        samples_checked++;
        if (rq.size() == 0) fail("unexpected word");
        else begin
            note = rq.pop_front();
            if (i_host_master.oe_last !== note[32]) fail("output enable wrong");
            if (note[33] && i_host_master.rx_last !== note[31:0]) fail("read word differs");
        end
    end

    initial begin
        repeat (60000) @(posedge clock);
        fail("timeout");
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        sample_ready_pulse = 1'b0;
        flip = 1'b0;
        clk_en = 1'b1;
        lock_key = 8'hA5;
        seed = 32'h0000_0063;
        cfg_word = 32'h0000_0000;
        failures = 0;
        samples_checked = 0;
        rl = 2'h2;
        wl = 1'b1;
        wd = 2'h1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        check(read_loop === 2'h2 && write_loop === 1'b1 && data_width === 2'h1
              && latch_all_channels === 1'b1 && sdo_oe === 1'b0, "reset values");
        seq(2'h1, 5'h10, 1'b0, 3, 1'b1);
        seq(2'h1, 5'h0F, 1'b0, 2, 1'b1);
        seq(2'h1, 5'h03, 1'b0, 1, 1'b0);
        i_host_master.begin_frame();
        send({24'h00_0000, 2'h1, 5'h11, 1'b0}, 8, 1'b0, 1'b0, 32'h0000_0000);
        send(rnd(), 10, 1'b0, 1'b0, 32'h0000_0000);
        i_host_master.end_frame();
        seq(2'h1, 5'h11, 1'b0, 1, 1'b1);
        seq(2'h2, 5'h10, 1'b1, 2, 1'b0);
        seq(2'h0, 5'h10, 1'b0, 1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            cfg_word = {26'h000_0000, m, m[0], m, m[1]};
            seq(2'h1, 5'h0C, 1'b0, 1, 1'b1);
            rl = m;
            wl = m[0];
            wd = m;
            check(read_loop === m && write_loop === m[0] && data_width === m
                  && latch_all_channels === m[1], "config");
            seq(2'h1, 5'h17, 1'b1, 3, 1'b1);
            seq(2'h1, 5'h0A, 1'b0, 2, 1'b1);
        end
        i_host_master.set_mode(1'b1);
        seq(2'h1, 5'h17, 1'b1, 2, 1'b1);
        // A frozen block must not act on a whole frame
        clk_en = 1'b0;
        seq(2'h1, 5'h1F, 1'b0, 1, 1'b0);
        clk_en = 1'b1;
        lock_key = 8'h00;
        seq(2'h1, 5'h10, 1'b0, 1, 1'b0);
        seq(2'h1, 5'h1F, 1'b0, 1, 1'b1);
        wrap_up();
    end
endmodule : test_spi_register_access_port
